// [nspd_pkg.sv]
// nspd_pkg: register map, field layout, widths and reset values of the signal dac
// assumes apb slave with 32-bit data, one register per aligned word
package nspd_pkg;
  // ---------------------------------------------------------------
  // register byte addresses
  // ---------------------------------------------------------------
  localparam logic [11:0] NSPD_ADDR_IN_LOW = 12'h000;
  localparam logic [11:0] NSPD_ADDR_IN_HIGH = 12'h004;
  localparam logic [11:0] NSPD_ADDR_CFG0 = 12'h008;
  localparam logic [11:0] NSPD_ADDR_CFG1 = 12'h00C;
  localparam logic [11:0] NSPD_ADDR_STATUS = 12'h010;
  // ---------------------------------------------------------------
  // cfg0 fields
  // ---------------------------------------------------------------
  localparam int NSPD_ORDER_MSB = 7;
  localparam int NSPD_ORDER_LSB = 6;
  localparam int NSPD_RES_MSB = 5;
  localparam int NSPD_RES_LSB = 3;
  localparam int NSPD_EN_MSB = 2;
  localparam int NSPD_EN_LSB = 1;
  localparam int NSPD_HALF_BIT = 0;
  // ---------------------------------------------------------------
  // cfg1 fields
  // ---------------------------------------------------------------
  localparam int NSPD_INV_BIT = 0;
  localparam int NSPD_BW_BIT = 1;
  // ---------------------------------------------------------------
  // widths and reset values
  // ---------------------------------------------------------------
  localparam int NSPD_CODE_W = 16;
  localparam int NSPD_CNT_W = 11;
  localparam int NSPD_MIN_RES = 4;
  localparam logic [7:0] NSPD_BYTE_RST = 8'h00;
  localparam logic [15:0] NSPD_CODE_RST = 16'h0000;
  localparam logic [31:0] NSPD_RDATA_RST = 32'h00000000;
  localparam logic [10:0] NSPD_CNT_RST = 11'h000;
  localparam logic [10:0] NSPD_CNT_ONE = 11'h001;
  localparam logic [1:0] NSPD_ORD0 = 2'h0;
  localparam logic [1:0] NSPD_ORD1 = 2'h1;
  localparam logic [15:0] NSPD_FULL = 16'hFFFF;
endpackage

// [nspd_shaper.sv]
// nspd_shaper: error-feedback noise shaper, order 0, 1 or 2
// assumes step pulses once per pwm period; code in is already stable
`timescale 1ns/1ns
module nspd_shaper
  import nspd_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_sync_n,
  input wire logic step,
  input wire logic [15:0] code_in,
  input wire logic [1:0] order,
  input wire logic [3:0] res_bits,
  output logic [10:0] duty
);
  logic signed [18:0] err1;
  logic signed [18:0] err2;
  logic signed [19:0] want;
  logic signed [19:0] quant;
  logic signed [19:0] clip;
  logic [4:0] shift;
  logic signed [19:0] lsb;
  logic signed [19:0] maxv;

  // ---------------------------------------------------------------
  // shaping arithmetic
  // ---------------------------------------------------------------
  always_comb
  begin
    shift = 5'(NSPD_CODE_W) - {1'b0, res_bits};
    lsb = 20'sd1 <<< shift;
    maxv = $signed({4'h0, NSPD_FULL}) - (lsb - 20'sd1);
    if (order == NSPD_ORD0)
      want = $signed({4'h0, code_in});
    else if (order == NSPD_ORD1)
      want = $signed({4'h0, code_in}) + 20'(err1);
    else
      want = $signed({4'h0, code_in}) + 20'(err1 <<< 1) - 20'(err2);
    // saturate to 0 and maxv, hence quant stays within the m-bit duty range at the rails
    if (want < 20'sd0)
      clip = 20'sd0;
    else if (want > maxv)
      clip = maxv;
    else
      clip = want;
    quant = (clip >>> shift) <<< shift;
  end

  // new code only at period boundary
  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      err1 <= '0;
      err2 <= '0;
      duty <= NSPD_CNT_RST;
    end
    else if (step)
    begin
      // error taken after the clamp, so a code at the rails cannot wind up the loop
      err1 <= (order == NSPD_ORD0) ? 19'sd0 : 19'(clip - quant); // RULE_04
      err2 <= (order == NSPD_ORD0) ? 19'sd0 : err1;
      duty <= 11'(quant >>> shift); // RULE_02
    end
  end
endmodule

// [nspd_dac.sv]
// nspd_dac: apb register file, input code sync, noise shaper and pwm modulator
// assumes apb master on mclk; pwm_out feeds the external amplifier and filter
//
// Contract
// RULE_01 - input codes are up to 16 bits, narrower codes left-aligned with zero fill.
// RULE_02 - shaper order is selectable as 0, 1 or 2, order 0 passes the truncated code.
// RULE_03 - pwm resolution m is programmable from 4 to 11 bits.
// RULE_04 - the shaper turns each code into a stream of m-bit codes whose average is the code; codes above maxv average to maxv, as the shaper clamps there.
// RULE_05 - an m-bit pwm uses an m-bit counter, one period being 2 to the m steps.
// RULE_06 - the 16-bit code written as two bytes is never used as a mix of old and new.
// RULE_07 - the modulator clock is the full clock or half of it.
// RULE_08 - output polarity is programmable active high or active low.
// RULE_09 - the buffered code passes on only when the high byte is written, low byte first.
// RULE_10 - resolution codes 000 to 111 map to 4 through 11 bits.
// RULE_11 - the halving bit selects full clock at 0 and half clock at 1.
// RULE_12 - invert bit 0 gives active high output, 1 gives active low.
// RULE_13 - a new m-bit code reaches the counter only at a period boundary.
//
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/1ns
module nspd_dac
  import nspd_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic pwm_out,
  output logic dac_enable,
  output logic amp_enable,
  output logic amp_wide_bw
);
  logic rst_meta_n;
  logic rst_sync_n;
  logic [7:0] input_code_low_byte;
  logic [7:0] input_code_high_byte;
  logic [15:0] active_code;
  logic [1:0] shaper_order_code;
  logic [2:0] pwm_resolution_code;
  logic [1:0] enable_bits;
  logic clock_half;
  logic output_invert;
  logic wide_bw;
  logic [5:0] cfg1_spare;
  logic half_phase;
  logic tick;
  logic [10:0] pwm_count;
  logic [10:0] period_last;
  logic [10:0] duty;
  logic [3:0] res_bits;
  logic step;
  logic period_done;
  logic access;
  logic wr_en;
  logic addr_ok;

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // ---------------------------------------------------------------
  // apb slave, zero wait states
  // ---------------------------------------------------------------
  assign access = psel && penable;
  assign wr_en = access && pwrite;
  assign addr_ok = (paddr == NSPD_ADDR_IN_LOW) || (paddr == NSPD_ADDR_IN_HIGH) ||
                   (paddr == NSPD_ADDR_CFG0) || (paddr == NSPD_ADDR_CFG1) ||
                   (paddr == NSPD_ADDR_STATUS);

  // pready registered high from setup so every access phase ends in one cycle
  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      prdata <= NSPD_RDATA_RST;
    else if (psel && !penable && !pwrite)
    begin
      unique case (paddr)
        NSPD_ADDR_IN_LOW: prdata <= {24'h000000, input_code_low_byte};
        NSPD_ADDR_IN_HIGH: prdata <= {24'h000000, input_code_high_byte};
        NSPD_ADDR_CFG0: prdata <= {24'h000000, shaper_order_code, pwm_resolution_code,
                                   enable_bits, clock_half};
        NSPD_ADDR_CFG1: prdata <= {24'h000000, cfg1_spare, wide_bw, output_invert};
        NSPD_ADDR_STATUS: prdata <= {5'h00, duty, 5'h00, pwm_count};
        default: prdata <= NSPD_RDATA_RST;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // input code bytes and transfer
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      input_code_low_byte <= NSPD_BYTE_RST;
      input_code_high_byte <= NSPD_BYTE_RST;
    end
    else if (wr_en && pready)
    begin
      if (paddr == NSPD_ADDR_IN_LOW)
        input_code_low_byte <= pwdata[7:0];
      if (paddr == NSPD_ADDR_IN_HIGH)
        input_code_high_byte <= pwdata[7:0];
    end
  end

  // low byte alone never reaches the converter
  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      active_code <= NSPD_CODE_RST;
    else if (wr_en && pready && paddr == NSPD_ADDR_IN_HIGH)
      active_code <= {pwdata[7:0], input_code_low_byte}; // RULE_06 RULE_09 RULE_01
  end

  // ---------------------------------------------------------------
  // configuration
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      shaper_order_code <= NSPD_ORD0;
      pwm_resolution_code <= 3'h0;
      enable_bits <= 2'h0;
      clock_half <= 1'b0;
      output_invert <= 1'b0;
      wide_bw <= 1'b0;
      cfg1_spare <= 6'h00;
    end
    else if (wr_en && pready)
    begin
      if (paddr == NSPD_ADDR_CFG0)
      begin
        shaper_order_code <= pwdata[NSPD_ORDER_MSB:NSPD_ORDER_LSB];
        pwm_resolution_code <= pwdata[NSPD_RES_MSB:NSPD_RES_LSB];
        enable_bits <= pwdata[NSPD_EN_MSB:NSPD_EN_LSB];
        clock_half <= pwdata[NSPD_HALF_BIT];
      end
      if (paddr == NSPD_ADDR_CFG1)
      begin
        output_invert <= pwdata[NSPD_INV_BIT];
        wide_bw <= pwdata[NSPD_BW_BIT];
        cfg1_spare <= pwdata[7:2];
      end
    end
  end

  // ---------------------------------------------------------------
  // modulator clock and counter
  // ---------------------------------------------------------------
  assign res_bits = 4'(NSPD_MIN_RES) + {1'b0, pwm_resolution_code}; // RULE_10 RULE_03
  // all-ones in the low m bits marks the last step of a period
  assign period_last = 11'((NSPD_CNT_ONE << res_bits) - NSPD_CNT_ONE); // RULE_05
  assign tick = !clock_half || half_phase; // RULE_07 RULE_11
  assign period_done = tick && (pwm_count >= period_last);
  assign step = period_done && enable_bits[0];

  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      half_phase <= 1'b0;
    else
      half_phase <= clock_half ? !half_phase : 1'b0;
  end

  // a resolution cut that leaves the count past the new last step wraps at once through the >= compare
  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      pwm_count <= NSPD_CNT_RST;
    else if (!enable_bits[0] || period_done)
      pwm_count <= NSPD_CNT_RST;
    else if (tick)
      pwm_count <= pwm_count + NSPD_CNT_ONE; // RULE_05
  end

  nspd_shaper u_shaper (
    .mclk(mclk),
    .rst_sync_n(rst_sync_n),
    .step(step), // RULE_13
    .code_in(active_code),
    .order(shaper_order_code),
    .res_bits(res_bits),
    .duty(duty)
  );

  // ---------------------------------------------------------------
  // output stage
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      pwm_out <= 1'b0;
    else if (!enable_bits[0])
      pwm_out <= output_invert; // RULE_12
    else
      pwm_out <= (pwm_count < duty) ^ output_invert; // RULE_08 RULE_12
  end

  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      dac_enable <= 1'b0;
      amp_enable <= 1'b0;
      amp_wide_bw <= 1'b0;
    end
    else
    begin
      dac_enable <= enable_bits[0];
      amp_enable <= enable_bits[1];
      amp_wide_bw <= wide_bw;
    end
  end
endmodule

// [nspd_dac_assertions.sv]
// nspd_dac_assertions: port checker for nspd_dac, bound to every instance
// assumes apb writes land at the edge where psel, penable and pready are high
`timescale 1ns/1ns
module nspd_dac_assertions
  import nspd_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic pwm_out,
  input wire logic dac_enable,
  input wire logic amp_enable,
  input wire logic amp_wide_bw
);
  // ---------------------------------------------------------------
  // register mirror and pulse grid
  // ---------------------------------------------------------------
  logic [7:0] c0, c1, lo, hi;
  logic [15:0] quiet, gap;
  logic act_q, seen;
  int per;
  wire logic wr = psel && penable && pready && pwrite;
  wire logic rd = psel && penable && pready && !pwrite;
  // any cfg write restarts the settle count
  wire logic cw = wr && paddr[3];
  // active level of the pulse, whatever the polarity
  wire logic act = pwm_out ^ c1[0];
  wire logic rise = act && !act_q && quiet > 16'd3;
  assign per = (16 << c0[5:3]) << c0[0];
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      c0 <= 8'h00;
      c1 <= 8'h00;
      lo <= 8'h00;
      hi <= 8'h00;
      quiet <= 16'h0000;
    end
    else
    begin
      if (wr && paddr == NSPD_ADDR_CFG0) c0 <= pwdata[7:0];
      if (wr && paddr == NSPD_ADDR_CFG1) c1 <= pwdata[7:0];
      if (wr && paddr == NSPD_ADDR_IN_LOW) lo <= pwdata[7:0];
      if (wr && paddr == NSPD_ADDR_IN_HIGH) hi <= pwdata[7:0];
      quiet <= cw ? 16'h0000 : quiet + {15'h0000, quiet != 16'hFFFF};
    end
  end
  // gap wraps at 2^16, still a multiple of every period
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      act_q <= 1'b0;
      seen <= 1'b0;
      gap <= 16'h0000;
    end
    else
    begin
      act_q <= act;
      seen <= !cw && (seen || rise);
      gap <= rise ? 16'h0001 : gap + 16'h0001;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_idle; !c0[1] && quiet > 16'd3 |-> pwm_out == c1[0]; endproperty
  a_idle: assert property (p_idle) else $error("idle level wrong");
  property p_inv; wr && paddr == NSPD_ADDR_CFG1 && !c0[1] |=> ##[0:3] pwm_out == c1[0]; endproperty
  a_inv: assert property (p_inv) else $error("polarity not applied");
  property p_grid; seen && rise |-> gap % per == 0; endproperty
  a_grid: assert property (p_grid) else $error("pulse off period grid");
  property p_half; c0[1] && c0[0] && quiet > 16'd3 && $changed(pwm_out) |=> $stable(pwm_out); endproperty
  a_half: assert property (p_half) else $error("half rate step");
  property p_st0; rd && paddr == NSPD_ADDR_STATUS && !c0[1] && quiet > 16'd3 |-> prdata[10:0] == 11'h000; endproperty
  a_st0: assert property (p_st0) else $error("count runs while disabled");
  property p_c0; rd && paddr == NSPD_ADDR_CFG0 |-> prdata[7:0] == c0; endproperty
  a_c0: assert property (p_c0) else $error("cfg0 readback");
  property p_c1; rd && paddr == NSPD_ADDR_CFG1 |-> prdata[7:0] == c1; endproperty
  a_c1: assert property (p_c1) else $error("cfg1 readback");
  property p_code; rd && paddr[11:3] == 9'h000 |-> prdata[7:0] == (paddr[2] ? hi : lo); endproperty
  a_code: assert property (p_code) else $error("code byte readback");
endmodule
bind nspd_dac nspd_dac_assertions u_nspd_dac_assertions (.mclk(mclk), .rst_n(rst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .pwm_out(pwm_out),
  .dac_enable(dac_enable), .amp_enable(amp_enable), .amp_wide_bw(amp_wide_bw));

// [tb.sv]
// tb: self-checking bench for nspd_dac, apb master and pwm high-time counter
// assumes the register map of nspd_pkg; the master waits for pready at rising edges
`timescale 1ns/1ns
module tb
  import nspd_pkg::*;
;
  logic mclk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready, pslverr, pwm_out, dac_enable, amp_enable, amp_wide_bw;
  int err_total = 0;
  int n_tests = 0;
  always #4 mclk = ~mclk;
  nspd_dac u_nspd_dac (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pwm_out(pwm_out), .dac_enable(dac_enable),
    .amp_enable(amp_enable), .amp_wide_bw(amp_wide_bw));
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    int g;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    g = 0;
    // answer and read data are taken at the rising edge that sees pready
    do
    begin
      @(posedge mclk);
      g++;
    end
    while (pready !== 1'b1 && g < 20);
    check("pready", pready, 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, {24'h000000, d}, r, e);
  endtask
  // settle two periods, then count high cycles over n whole periods
  task automatic meas(input int p, input int n, input int exp, input int tol);
    int hi;
    repeat (2 * p + 8) @(posedge mclk);
    hi = 0;
    repeat (n * p)
    begin
      @(negedge mclk);
      hi += (pwm_out === 1'b1);
    end
    check("pwm high cycles", (hi - exp <= tol && exp - hi <= tol) ? exp : hi, exp);
  endtask
  task automatic pwm_case(input logic [1:0] o, input logic [2:0] r, input logic h,
    input logic i, input logic [15:0] c, input int n, input int exp, input int tol);
    wr(NSPD_ADDR_CFG0, 8'h00);
    wr(NSPD_ADDR_IN_LOW, c[7:0]);
    wr(NSPD_ADDR_IN_HIGH, c[15:8]);
    wr(NSPD_ADDR_CFG1, {7'h00, i});
    wr(NSPD_ADDR_CFG0, {o, r, 2'b01, h});
    meas((16 << r) * (h ? 2 : 1), n, exp, tol);
    check("dac enable", dac_enable, 1'b1);
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_regs();
    logic [31:0] r;
    logic e;
    for (int a = 0; a < 5; a++)
    begin
      apb(1'b0, 12'(a * 4), 32'h00000000, r, e);
      check("reset value", r, 32'h00000000);
      check("mapped error", e, 1'b0);
    end
    wr(NSPD_ADDR_CFG0, 8'hA4);
    apb(1'b0, NSPD_ADDR_CFG0, 32'h00000000, r, e);
    check("cfg0 readback", r[7:0], 8'hA4);
    check("enables", {dac_enable, amp_enable}, 2'b01);
    wr(NSPD_ADDR_CFG1, 8'hFE);
    apb(1'b0, NSPD_ADDR_CFG1, 32'h00000000, r, e);
    check("cfg1 readback", r[7:0], 8'hFE);
    check("wide bandwidth", amp_wide_bw, 1'b1);
    apb(1'b0, 12'h020, 32'h00000000, r, e);
    check("unmapped error", e, 1'b1);
    check("unmapped data", r, 32'h00000000);
    apb(1'b0, NSPD_ADDR_STATUS, 32'h00000000, r, e);
    check("status count", r[10:0], 11'h000);
    $display("t_regs done");
  endtask
  task automatic t_res();
    for (int r = 0; r < 8; r++)
      pwm_case(2'h0, 3'(r), 1'b0, 1'b0, 16'h5A5A, 2, 2 * (16'h5A5A >> (12 - r)), 0);
    $display("t_res done");
  endtask
  task automatic t_half_inv();
    pwm_case(2'h0, 3'h0, 1'b1, 1'b0, 16'h5A5A, 2, 20, 0);
    pwm_case(2'h0, 3'h1, 1'b0, 1'b1, 16'h5A5A, 2, 64 - 22, 0);
    wr(NSPD_ADDR_CFG0, 8'h00);
    repeat (4) @(negedge mclk);
    check("idle level", pwm_out, 1'b1);
    $display("t_half_inv done");
  endtask
  task automatic t_sync();
    pwm_case(2'h0, 3'h7, 1'b0, 1'b0, 16'h8000, 1, 1024, 0);
    wr(NSPD_ADDR_IN_LOW, 8'hE0);
    meas(2048, 1, 1024, 0);
    wr(NSPD_ADDR_IN_HIGH, 8'h80);
    meas(2048, 1, 1031, 0);
    $display("t_sync done");
  endtask
  task automatic t_order();
    for (int o = 1; o < 4; o++)
      pwm_case(2'(o), 3'h0, 1'b0, 1'b0, 16'h5400, 64, 336, 4);
    pwm_case(2'h1, 3'h0, 1'b0, 1'b0, 16'hFFFF, 64, 960, 0);
    $display("t_order done");
  endtask
  // reset in mid-run, with the converter running and every register written
  task automatic t_reset();
    logic [31:0] r;
    logic e;
    wr(NSPD_ADDR_IN_LOW, 8'h12);
    wr(NSPD_ADDR_IN_HIGH, 8'h34);
    wr(NSPD_ADDR_CFG1, 8'h03);
    wr(NSPD_ADDR_CFG0, 8'hFF);
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    check("reset outputs", {pwm_out, dac_enable, amp_enable, amp_wide_bw}, 4'h0);
    for (int a = 0; a < 5; a++)
    begin
      apb(1'b0, 12'(a * 4), 32'h00000000, r, e);
      check("value after reset", r, 32'h00000000);
    end
    $display("t_reset done");
  endtask
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    #640000;
    err_total++;
    $display("Error watchdog: expected end of tests, seen timeout");
    finish_test();
  end
  initial
  begin
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    t_regs();
    t_res();
    t_half_inv();
    t_sync();
    t_order();
    t_reset();
    finish_test();
  end
endmodule
